// ==== uart_async_receiver.sv ====
// Top: register file, receive buffer, error flags and interrupt for the UART receiver
`timescale 1ns/1ns
// Function
// R01 - Software selects async mode then enables port
// R02 - Ninth-bit enable selects nine or eight bits
// R03 - Receive continuously while continuous enable set
// R04 - Continuous receive overrides single receive enable
// R05 - Framing error flag refreshed per character
// R06 - Clearing continuous enable clears overrun flag
// R07 - Ninth received bit shown in status register
// R08 - Flag on character done; interrupt if enabled
// R09 - Low eight bits in receive data register
// R10 - Software loads divisor before enabling reception
// R11 - Software sets interrupt enable before reception
// R12 - Status bit 3 reads as zero
// R13 - Software reads status before data byte
// R14 - Start on falling edge, mid-bit sample, stop check
// R15 - Overrun on full buffer; reception suspended
module uart_async_receiver (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Serial line
  input wire logic rx_i,
  // Interrupt and pin ownership
  output logic irq_o,
  output logic port_en_o
);
  // ==========================================
  // Reset release and line synchroniser
  logic rst_s1_r, rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end
  logic rx_s1_r, rx_s2_r;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else if (ce_i) begin
      rx_s1_r <= rx_i;
      rx_s2_r <= rx_s1_r;
    end
  end
  // ==========================================
  // Registers
  logic [7:0] ctl_r, ctl_nxt;     // receive_status_control writable part
  logic [7:0] tx_r, tx_nxt;       // transmit_status_control
  logic [7:0] baud_r, baud_nxt;
  logic [7:0] pie_r, pie_nxt;
  logic [7:0] pir_r, pir_nxt;
  logic [7:0] rdata_nxt;
  // Two-deep receive buffer, each entry {framing_error_flag, ninth, data}
  logic [9:0] buf_r [2];
  logic [9:0] buf_nxt [2];
  logic [1:0] cnt_r, cnt_nxt;
  logic overrun_error_flag_r, overrun_error_flag_nxt;
  logic irq_nxt, pen_nxt;
  logic done;
  logic [8:0] cdata;
  logic cferr;
  logic run;
  logic port_on, cont_on, single_on, sync;
  logic [7:0] status_rd;
  always_comb begin
    port_on = ctl_r[uart_rx_pkg::PORT_EN_BIT]; // [R01]
    cont_on = ctl_r[uart_rx_pkg::CONT_EN_BIT];
    single_on = ctl_r[uart_rx_pkg::SINGLE_EN_BIT];
    sync = tx_r[uart_rx_pkg::SYNC_BIT];
    // Synchronous master: continuous overrides single; async ignores single [R04]
    run = port_on && !overrun_error_flag_r && (cont_on || (sync && tx_r[uart_rx_pkg::CLK_SRC_BIT] && single_on)); // [R03]
    status_rd = {ctl_r[7:4], 1'b0, buf_r[0][9], overrun_error_flag_r, buf_r[0][8]}; // [R12] [R07] [R05]
  end
  uart_rx_core core (
    .clk_i(clk_i),
    .rst_n(rst_n),
    .ce_i(ce_i),
    .run_i(run),
    .nine_i(ctl_r[uart_rx_pkg::NINE_EN_BIT]), // [R02]
    .high_i(tx_r[uart_rx_pkg::HIGH_BAUD_BIT]),
    .div_i(baud_r),
    .rx_i(rx_s2_r),
    .done_o(done),
    .data_o(cdata),
    .framing_error_flag_o(cferr)
  );
  logic pop;
  logic [9:0] entry;
  always_comb begin
    ctl_nxt = ctl_r;
    tx_nxt = tx_r;
    baud_nxt = baud_r;
    pie_nxt = pie_r;
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    overrun_error_flag_nxt = overrun_error_flag_r;
    rdata_nxt = 8'h00;
    pop = rd_i && (addr_i == uart_rx_pkg::RXDATA_OFS) && (cnt_r != 2'd0);
    entry = {cferr, ctl_r[uart_rx_pkg::NINE_EN_BIT] ? cdata[8] : 1'b0, cdata[7:0]};
    if (wr_i) begin
      case (addr_i)
        uart_rx_pkg::RXSTAT_OFS: begin
          ctl_nxt = wdata_i & uart_rx_pkg::RXSTAT_WMASK;
        end
        uart_rx_pkg::TXSTAT_OFS: begin
          tx_nxt = (wdata_i & uart_rx_pkg::TXSTAT_WMASK) | (tx_r & ~uart_rx_pkg::TXSTAT_WMASK);
        end
        uart_rx_pkg::BAUD_OFS: baud_nxt = wdata_i;
        uart_rx_pkg::PIE_OFS: pie_nxt = wdata_i;
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        uart_rx_pkg::PIR_OFS: rdata_nxt = pir_r;
        uart_rx_pkg::RXSTAT_OFS: rdata_nxt = status_rd;
        uart_rx_pkg::RXDATA_OFS: rdata_nxt = buf_r[0][7:0]; // [R09]
        uart_rx_pkg::PIE_OFS: rdata_nxt = pie_r;
        uart_rx_pkg::TXSTAT_OFS: rdata_nxt = tx_r;
        uart_rx_pkg::BAUD_OFS: rdata_nxt = baud_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // Reading the data pops the head; status then shows the next entry [R05]
    if (pop) begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt = cnt_r - 2'd1;
    end
    if (done) begin
      if (cnt_nxt == 2'd2) begin
        overrun_error_flag_nxt = 1'b1; // [R15]
      end else begin
        buf_nxt[cnt_nxt[0]] = entry;
        cnt_nxt = cnt_nxt + 2'd1;
      end
    end
    // Dropping continuous enable recovers from overrun [R06]
    if (!ctl_nxt[uart_rx_pkg::CONT_EN_BIT]) begin
      overrun_error_flag_nxt = 1'b0;
    end
    // Receive flag follows buffer occupancy; reading the last buffered entry clears it [R08]
    pir_nxt = 8'h00;
    pir_nxt[uart_rx_pkg::RX_FLAG_BIT] = (cnt_nxt != 2'd0);
    irq_nxt = |(pir_nxt & pie_nxt); // [R08]
    pen_nxt = ctl_nxt[uart_rx_pkg::PORT_EN_BIT];
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= uart_rx_pkg::RXSTAT_RST;
      tx_r <= uart_rx_pkg::TXSTAT_RST;
      baud_r <= uart_rx_pkg::BAUD_RST;
      pie_r <= uart_rx_pkg::PIE_RST;
      pir_r <= uart_rx_pkg::PIR_RST;
      buf_r[0] <= 10'h000;
      buf_r[1] <= 10'h000;
      cnt_r <= 2'd0;
      overrun_error_flag_r <= 1'b0;
      rdata_o <= uart_rx_pkg::RXDATA_RST;
      irq_o <= 1'b0;
      port_en_o <= 1'b0;
    end else if (ce_i) begin
      ctl_r <= ctl_nxt;
      tx_r <= tx_nxt;
      baud_r <= baud_nxt;
      pie_r <= pie_nxt;
      pir_r <= pir_nxt;
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
      overrun_error_flag_r <= overrun_error_flag_nxt;
      rdata_o <= rdata_nxt;
      irq_o <= irq_nxt;
      port_en_o <= pen_nxt;
    end
  end
  // ==========================================
  // Checks
  a_irq_gate: assert property (@(posedge clk_i) disable iff (!rst_n) // [R08]
    ce_i |=> (irq_o == (pir_r[uart_rx_pkg::RX_FLAG_BIT] & pie_r[uart_rx_pkg::RX_FLAG_BIT])))
    else $error("irq does not follow flag and enable");
  a_overrun_error_flag_clear: assert property (@(posedge clk_i) disable iff (!rst_n) // [R06]
    (ce_i && !ctl_r[uart_rx_pkg::CONT_EN_BIT]) |-> !overrun_error_flag_r)
    else $error("overrun kept while continuous enable clear");
  a_bit3_zero: assert property (@(posedge clk_i) disable iff (!rst_n) // [R12]
    (ce_i && rd_i && addr_i == uart_rx_pkg::RXSTAT_OFS) |=> !rdata_o[3])
    else $error("status bit 3 not zero");
  a_done_flag: assert property (@(posedge clk_i) disable iff (!rst_n) // [R08]
    (ce_i && done) |=> pir_r[uart_rx_pkg::RX_FLAG_BIT])
    else $error("receive flag not set after character");
  a_overrun_set: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
    (ce_i && done && cnt_r == 2'd2 && !pop && ctl_nxt[uart_rx_pkg::CONT_EN_BIT]) |=> overrun_error_flag_r)
    else $error("overrun not flagged");
  a_suspend: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
    overrun_error_flag_r |-> !run)
    else $error("reception not suspended");
  a_run_cont: assert property (@(posedge clk_i) disable iff (!rst_n) // [R03]
    (port_on && cont_on && !overrun_error_flag_r) |-> run)
    else $error("continuous receive not running");
  a_data_read: assert property (@(posedge clk_i) disable iff (!rst_n) // [R09]
    (ce_i && rd_i && addr_i == uart_rx_pkg::RXDATA_OFS) |=> (rdata_o == $past(buf_r[0][7:0])))
    else $error("receive data read wrong");
endmodule // uart_async_receiver

// ==== uart_rx_pkg.sv ====
// Package: register map, field positions, reset values and timing for the UART receiver
package uart_rx_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] PIR_OFS = 8'h0C;
  localparam logic [7:0] RXSTAT_OFS = 8'h18;
  localparam logic [7:0] RXDATA_OFS = 8'h1A;
  localparam logic [7:0] PIE_OFS = 8'h8C;
  localparam logic [7:0] TXSTAT_OFS = 8'h98;
  localparam logic [7:0] BAUD_OFS = 8'h99;
  // receive_status_control fields
  localparam int PORT_EN_BIT = 7;
  localparam int NINE_EN_BIT = 6;
  localparam int SINGLE_EN_BIT = 5;
  localparam int CONT_EN_BIT = 4;
  localparam int FRAME_ERR_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int NINTH_BIT = 0;
  // transmit_status_control fields
  localparam int SYNC_BIT = 4;
  localparam int HIGH_BAUD_BIT = 2;
  localparam int CLK_SRC_BIT = 7;
  // Interrupt flag / enable position
  localparam int RX_FLAG_BIT = 5;
  // Reset values
  localparam logic [7:0] PIR_RST = 8'h00;
  localparam logic [7:0] PIE_RST = 8'h00;
  localparam logic [7:0] RXSTAT_RST = 8'h00;
  localparam logic [7:0] TXSTAT_RST = 8'h02;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] RXDATA_RST = 8'h00;
  // Writable masks
  localparam logic [7:0] RXSTAT_WMASK = 8'hF0;
  localparam logic [7:0] TXSTAT_WMASK = 8'hF5;
  // Oversampling: 16 ticks per bit normally, 4 with high speed select
  localparam logic [4:0] OVS_LOW = 5'h10;
  localparam logic [4:0] OVS_HIGH = 5'h04;
  // Clock
  localparam int CLK_MHZ = 100;
  // Receiver state
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_STOP = 3'b010,
    RX_HOLD = 3'b110
  } rx_state_t;
endpackage

// ==== uart_rx_core.sv ====
// Serial receive engine: start detect, mid-bit sampling, stop check
`timescale 1ns/1ns
module uart_rx_core (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic nine_i,
  input wire logic high_i,
  input wire logic [7:0] div_i,
  // Synchronised line
  input wire logic rx_i,
  // Character out
  output logic done_o,
  output logic [8:0] data_o,
  output logic framing_error_flag_o
);
  // ==========================================
  // Baud tick
  logic [7:0] div_r, div_nxt;
  logic tick;
  always_comb begin
    tick = (div_r == 8'h00);
    div_nxt = tick ? div_i : div_r - 8'h01;
    if (!run_i) begin
      div_nxt = div_i;
    end
  end
  // ==========================================
  // Bit framing
  uart_rx_pkg::rx_state_t st_r, st_nxt;
  logic [4:0] ovs_r, ovs_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic done_nxt, framing_error_flag_nxt;
  logic [4:0] ovs_len;
  logic [3:0] nbits;
  always_comb begin
    ovs_len = high_i ? uart_rx_pkg::OVS_HIGH : uart_rx_pkg::OVS_LOW;
    nbits = nine_i ? 4'h9 : 4'h8; // [R02]
    st_nxt = st_r;
    ovs_nxt = ovs_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    done_nxt = 1'b0;
    framing_error_flag_nxt = framing_error_flag_o;
    if (!run_i) begin
      st_nxt = uart_rx_pkg::RX_IDLE; // [R03]
    end else if (tick) begin
      case (st_r)
        uart_rx_pkg::RX_IDLE: begin
          if (!rx_i) begin // [R14]
            st_nxt = uart_rx_pkg::RX_START;
            ovs_nxt = {1'b0, ovs_len[4:1]} - 5'h01;
          end
        end
        uart_rx_pkg::RX_START: begin
          if (ovs_r != 5'h00) begin
            ovs_nxt = ovs_r - 5'h01;
          end else if (rx_i) begin
            st_nxt = uart_rx_pkg::RX_IDLE;
          end else begin
            st_nxt = uart_rx_pkg::RX_DATA;
            ovs_nxt = ovs_len - 5'h01;
            bit_nxt = 4'h0;
          end
        end
        uart_rx_pkg::RX_DATA: begin
          if (ovs_r != 5'h00) begin
            ovs_nxt = ovs_r - 5'h01;
          end else begin
            // LSB first; shift in from the top of the used width
            sh_nxt = nine_i ? {rx_i, sh_r[8:1]} : {1'b0, rx_i, sh_r[7:1]}; // [R14]
            ovs_nxt = ovs_len - 5'h01;
            bit_nxt = bit_r + 4'h1;
            if (bit_r == nbits - 4'h1) begin
              st_nxt = uart_rx_pkg::RX_STOP;
            end
          end
        end
        uart_rx_pkg::RX_STOP: begin
          if (ovs_r != 5'h00) begin
            ovs_nxt = ovs_r - 5'h01;
          end else begin
            framing_error_flag_nxt = !rx_i; // [R14]
            done_nxt = 1'b1;
            st_nxt = rx_i ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_HOLD;
          end
        end
        uart_rx_pkg::RX_HOLD: begin
          // Wait for line to return high after a broken stop bit
          if (rx_i) begin
            st_nxt = uart_rx_pkg::RX_IDLE;
          end
        end
        default: st_nxt = uart_rx_pkg::RX_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 8'h00;
      st_r <= uart_rx_pkg::RX_IDLE;
      ovs_r <= 5'h00;
      bit_r <= 4'h0;
      sh_r <= 9'h000;
      done_o <= 1'b0;
      framing_error_flag_o <= 1'b0;
    end else if (ce_i) begin
      div_r <= div_nxt;
      st_r <= st_nxt;
      ovs_r <= ovs_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      done_o <= done_nxt;
      framing_error_flag_o <= framing_error_flag_nxt;
    end
  end
  assign data_o = sh_r;
endmodule // uart_rx_core

// ==== uart_line_driver.sv ====
// Partner model: remote asynchronous serial transmitter on the receive line
`timescale 1ns/1ns
module uart_line_driver #(
  parameter int BIT_CYC = 8
) (
  // Clock
  input wire logic clk_i,
  // Serial line
  output logic line_o
);
  // ==========
  // Line behaviour
  initial begin
    line_o = 1'b1;
  end
  // Start bit, LSB-first data, one stop bit, then one idle bit period.
  // A low stop bit is the only fault this model makes, and only on request.
  task automatic send(input logic [8:0] data, input int nbits, input logic stop_bit);
    int i;
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_i);
    for (i = 0; i < nbits; i++) begin
      line_o <= data[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= stop_bit;
    repeat (BIT_CYC) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_i);
  endtask
endmodule // uart_line_driver

// ==== uart_async_receiver_tb_top.sv ====
// Testbench: register-level tests of the UART receiver against a serial line model
`timescale 1ns/1ns
module uart_async_receiver_tb_top;
  // ==========
  // Signals
  logic clk_i;
  logic rst_n_i;
  logic ce_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [7:0] rdata_o;
  logic rx_line;
  logic irq_o;
  logic port_en_o;
  int failures;
  int checked;
  // ==========
  // Clock, design and partner
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  uart_async_receiver dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_line), .irq_o(irq_o),
    .port_en_o(port_en_o)
  );
  // Divisor 1 with high baud select gives 2 clocks a tick, 4 ticks a bit
  uart_line_driver #(.BIT_CYC(8)) line (
    .clk_i(clk_i),
    .line_o(rx_line)
  );
  // ==========
  // Access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ==========
  // Watchdog: the tests need well under 3000 cycles
  initial begin
    #200000;
    failures++;
    give_verdict();
  end
  // ==========
  // Tests
  initial begin
    failures = 0;
    checked = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset values and an unmapped address
    expect_reg(uart_rx_pkg::PIR_OFS, 8'h00);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h00);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h00);
    expect_reg(uart_rx_pkg::PIE_OFS, 8'h00);
    expect_reg(uart_rx_pkg::TXSTAT_OFS, 8'h02);
    expect_reg(uart_rx_pkg::BAUD_OFS, 8'h00);
    expect_reg(8'h40, 8'h00);
    check({7'h00, port_en_o}, 8'h00);
    // Setup order: divisor, async with high baud, interrupt enable, then receive
    write_reg(uart_rx_pkg::BAUD_OFS, 8'h01);
    write_reg(uart_rx_pkg::TXSTAT_OFS, 8'h04);
    write_reg(uart_rx_pkg::PIE_OFS, 8'h20);
    write_reg(uart_rx_pkg::RXSTAT_OFS, 8'h9F);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h90);
    check({7'h00, port_en_o}, 8'h01);
    // Plain 8-bit character, status read before data
    line.send(9'h0A5, 8, 1'b1);
    check({7'h00, irq_o}, 8'h01);
    expect_reg(uart_rx_pkg::PIR_OFS, 8'h20);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h90);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'hA5);
    expect_reg(uart_rx_pkg::PIR_OFS, 8'h00);
    check({7'h00, irq_o}, 8'h00);
    // Framing error, then refreshed by the next good character
    line.send(9'h03C, 8, 1'b0);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h94);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h3C);
    line.send(9'h011, 8, 1'b1);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h90);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h11);
    // Masked interrupt: flag set, request held low
    write_reg(uart_rx_pkg::PIE_OFS, 8'h00);
    line.send(9'h07E, 8, 1'b1);
    check({7'h00, irq_o}, 8'h00);
    expect_reg(uart_rx_pkg::PIR_OFS, 8'h20);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h7E);
    write_reg(uart_rx_pkg::PIE_OFS, 8'h20);
    // Overrun on the third unread character, cleared by dropping continuous receive
    line.send(9'h001, 8, 1'b1);
    line.send(9'h002, 8, 1'b1);
    line.send(9'h003, 8, 1'b1);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h92);
    write_reg(uart_rx_pkg::RXSTAT_OFS, 8'h80);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'h80);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h01);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h02);
    expect_reg(uart_rx_pkg::PIR_OFS, 8'h00);
    // Receiver stopped while continuous receive is clear
    line.send(9'h055, 8, 1'b1);
    expect_reg(uart_rx_pkg::PIR_OFS, 8'h00);
    // Clock enable low freezes state: a write in that time is lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    write_reg(uart_rx_pkg::BAUD_OFS, 8'h07);
    @(posedge clk_i);
    ce_i <= 1'b1;
    expect_reg(uart_rx_pkg::BAUD_OFS, 8'h01);
    // Nine-bit characters with both values of the ninth bit
    write_reg(uart_rx_pkg::RXSTAT_OFS, 8'hD0);
    line.send(9'h15A, 9, 1'b1);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'hD1);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'h5A);
    line.send(9'h0C3, 9, 1'b1);
    expect_reg(uart_rx_pkg::RXSTAT_OFS, 8'hD0);
    expect_reg(uart_rx_pkg::RXDATA_OFS, 8'hC3);
    give_verdict();
  end
endmodule // uart_async_receiver_tb_top
